// File: dsw_walker.sv
/*
 * Descriptor schedule walker with an AXI4-Lite register slave.
 * Walks the three descriptor lists once per microframe, hands
 * work to an external transaction engine, writes status back into
 * shared memory, groups completions into three interrupt lines and raises a fourth each microframe.
 * Assumes a memory port that acks each access and a transaction
 * engine that acks each request, both on core_clk.
 */
// Operation
// RULE1 - thirty-two slots in each of three lists
// RULE2 - isochronous first, then poll, then async
// RULE3 - async list carries control and bulk transfers
// RULE4 - done map, grouped through AND/OR masks
// RULE5 - four interrupts: iso, poll, async, frame
// RULE6 - interrupt latency in whole microframes
// RULE7 - forward link only; backward link never taken
// RULE8 - software never links one endpoint to itself
// RULE9 - walk slots upward honouring skip and final
// RULE10 - active, not-done descriptor gets a transaction
// RULE11 - branch target is link field of word four
// RULE12 - software puts final marker past link target
// RULE13 - software never skips a link target
// RULE14 - skipped slot ignored, next slot taken
// RULE15 - link of skipped slot is disregarded
// RULE16 - software allocates and frees slots
// RULE17 - branch flag picks next slot or link
// RULE18 - PID error: flag, clear active, retry thrice
// RULE19 - babble: flag, clear active
// RULE20 - after final slot, next list or idle

`timescale 1ns/1ps
module dsw_walker (
	input wire logic core_clk,
	input wire logic rst_n,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Shared descriptor memory
	output logic mem_req,
	output logic mem_we,
	output logic [9:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	// Transaction engine
	output logic xact_req,
	output dsw_pkg::dsw_list_t xact_list,
	output dsw_pkg::dsw_slot_t xact_slot,
	input wire logic xact_ack,
	input wire logic [1:0] xact_status,
	// Interrupt lines
	output logic irq_iso,
	output logic irq_poll,
	output logic irq_async,
	output logic irq_sof
);
	import dsw_pkg::*;

	dsw_s r; // All state
	dsw_s n; // Next state
	logic tick; // Microframe strobe
	logic wr_go; // Both write halves held
	logic [1:0] wl; // List index of write
	logic [1:0] rl; // List index of read
	logic [31:0] wm; // Write data merged with strobes
	logic [31:0] rd; // Read mux result
	logic rd_err; // Unmapped read
	logic fire; // Latency window elapsed
	logic grp; // Group condition of one list

	// Byte lanes select which bytes of the old value change
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				m[8*b +: 8] = d[8*b +: 8];
			end
		end
		return m;
	endfunction : merge

	// Handshake outputs straight from state
	assign s_axi_awready = !r.aw_ok && !r.bvalid;
	assign s_axi_wready = !r.w_ok && !r.bvalid;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	// Memory port held for the whole access state
	assign mem_req = (r.st == ST_RD3) || (r.st == ST_WB) || (r.st == ST_RD4);
	assign mem_we = (r.st == ST_WB);
	assign mem_addr = {r.list, r.slot, (r.st == ST_RD4) ? `DSW_WORD4 : `DSW_WORD3};
	assign mem_wdata = r.dw3;
	// Same engine serves all lists; async covers control and bulk
	assign xact_req = (r.st == ST_XACT); // see RULE10, RULE3
	assign xact_list = r.list;
	assign xact_slot = r.slot;
	// Four separate sources, each a register bit
	assign irq_iso = r.irq[0]; // see RULE5
	assign irq_poll = r.irq[1];
	assign irq_async = r.irq[2];
	assign irq_sof = r.irq[`DSW_IRQ_SOF];

	// Read mux; unmapped or list 3 answers SLVERR with zero data
	always_comb begin
		rl = s_axi_araddr[3:2];
		rd = `DSW_RST_WORD;
		rd_err = 1'b0;
		case (s_axi_araddr[7:4])
			`DSW_G_MISC: begin
				case (rl)
					`DSW_I_CTRL: rd = {31'h0, r.en};
					`DSW_I_LAT: rd = {24'h0, r.lat};
					`DSW_I_IRQ: rd = {28'h0, r.irq};
					default: rd = {22'h0, r.st, r.list, r.slot};
				endcase
			end
			`DSW_G_DONE: rd = r.done[rl];
			`DSW_G_OR: rd = r.orm[rl];
			`DSW_G_AND: rd = r.andm[rl];
			`DSW_G_SKIP: rd = r.skip[rl];
			`DSW_G_LAST: rd = r.last[rl];
			default: rd_err = 1'b1;
		endcase
		if (s_axi_araddr[7:4] != `DSW_G_MISC && rl == `DSW_BAD_LIST) begin
			rd_err = 1'b1;
		end
		if (rd_err || s_axi_araddr[1:0] != 2'h0) begin
			rd = `DSW_RST_WORD;
			rd_err = 1'b1;
		end
	end

	// Next-state logic: bus first, hardware sets last so set wins
	always_comb begin
		n = r;
		tick = (r.tick_cnt == 12'(`DSW_UFRAME_CYC - 1));
		wr_go = r.aw_ok && r.w_ok && !r.bvalid;
		wl = r.awaddr[3:2];
		wm = `DSW_RST_WORD;
		fire = 1'b0;
		grp = 1'b0;
		// Microframe divider
		n.tick_cnt = tick ? 12'h0 : r.tick_cnt + 12'h1;
		// Write address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			n.aw_ok = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.w_ok = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (wr_go) begin
			n.aw_ok = 1'b0;
			n.w_ok = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `DSW_RESP_OK;
			if (r.awaddr[1:0] != 2'h0) begin
				n.bresp = `DSW_RESP_SLV;
			end else if (r.awaddr[7:4] == `DSW_G_MISC) begin
				case (wl)
					`DSW_I_CTRL: begin
						// Only bit 0 enables; other bits are ignored
						wm = merge({31'h0, r.en}, r.wdata, r.wstrb);
						n.en = wm[0];
					end
					`DSW_I_LAT: begin
						wm = merge({24'h0, r.lat}, r.wdata, r.wstrb);
						n.lat = wm[7:0]; // see RULE6
					end
					`DSW_I_IRQ: n.irq = r.irq & ~(r.wstrb[0] ? r.wdata[3:0] : 4'h0);
					default: n.bresp = `DSW_RESP_OK; // Status is read-only
				endcase
			end else if (wl == `DSW_BAD_LIST) begin
				n.bresp = `DSW_RESP_SLV;
			end else begin
				case (r.awaddr[7:4])
					// Done map clears by writing ones
					`DSW_G_DONE: n.done[wl] = r.done[wl] & ~merge(32'h0, r.wdata, r.wstrb);
					`DSW_G_OR: n.orm[wl] = merge(r.orm[wl], r.wdata, r.wstrb);
					`DSW_G_AND: n.andm[wl] = merge(r.andm[wl], r.wdata, r.wstrb);
					`DSW_G_SKIP: n.skip[wl] = merge(r.skip[wl], r.wdata, r.wstrb);
					`DSW_G_LAST: n.last[wl] = merge(r.last[wl], r.wdata, r.wstrb);
					default: n.bresp = `DSW_RESP_SLV;
				endcase
			end
		end
		// Read channel
		if (s_axi_arvalid && !r.rvalid) begin
			n.rvalid = 1'b1;
			n.rdata = rd;
			n.rresp = rd_err ? `DSW_RESP_SLV : `DSW_RESP_OK;
		end else if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		// Walker
		case (r.st)
			ST_IDLE: begin
				// Each microframe restarts at slot 0 of the iso list
				if (tick && r.en) begin
					n.list = 2'h0; // see RULE2
					n.slot = 5'h0;
					n.st = ST_CHK;
				end
			end
			ST_CHK: begin
				n.br = 1'b0; // Skipped slot: its link is not used, see RULE15
				n.retry = 2'h0;
				n.st = r.skip[r.list][r.slot] ? ST_NEXT : ST_RD3; // see RULE14
			end
			ST_RD3: begin
				if (mem_ack) begin
					n.dw3 = mem_rdata;
					// Active and not yet done gets a transaction
					if (mem_rdata[`DSW_DW3_ACT] && !r.done[r.list][r.slot]) begin
						n.st = ST_XACT; // see RULE10
					end else begin
						n.st = ST_RD4;
					end
				end
			end
			ST_XACT: begin
				if (xact_ack) begin
					case (xact_status)
						`DSW_XS_OK: begin
							n.dw3[`DSW_DW3_ACT] = 1'b0;
							n.st = ST_WB;
						end
						`DSW_XS_PID: begin
							// Retry in place before reporting the error
							if (r.retry != `DSW_RETRY_MAX) begin
								n.retry = r.retry + 2'h1; // see RULE18
							end else begin
								n.dw3[`DSW_DW3_ERR] = 1'b1; // see RULE18
								n.dw3[`DSW_DW3_ACT] = 1'b0;
								n.st = ST_WB;
							end
						end
						default: begin
							n.dw3[`DSW_DW3_BAB] = 1'b1; // see RULE19
							n.dw3[`DSW_DW3_ACT] = 1'b0;
							n.st = ST_WB;
						end
					endcase
				end
			end
			ST_WB: begin
				if (mem_ack) begin
					n.st = ST_RD4;
				end
			end
			ST_RD4: begin
				if (mem_ack) begin
					n.br = mem_rdata[`DSW_DW4_BR]; // see RULE17
					n.link = mem_rdata[4:0]; // see RULE11
					n.st = ST_NEXT;
				end
			end
			ST_NEXT: begin
				n.st = ST_CHK;
				// Final marker or slot 31 ends this list
				if (r.last[r.list][r.slot] || r.slot == `DSW_LAST_SLOT) begin
					if (r.list == `DSW_LAST_LIST) begin
						n.st = ST_IDLE; // see RULE20
					end else begin
						n.list = r.list + 2'h1; // see RULE2
						n.slot = 5'h0;
					end
				end else if (r.br && r.link > r.slot) begin
					n.slot = r.link; // Forward only, see RULE7
				end else begin
					n.slot = r.slot + 5'h1; // see RULE9, RULE1
				end
			end
			default: n.st = ST_IDLE;
		endcase
		// Completion, whatever the outcome; set beats a clear
		if (r.st == ST_XACT && xact_ack &&
			(xact_status != `DSW_XS_PID || r.retry == `DSW_RETRY_MAX)) begin
			n.done[r.list][r.slot] = 1'b1; // see RULE4
		end
		// Latency window counts whole microframes
		if (tick) begin
			n.irq[`DSW_IRQ_SOF] = 1'b1; // see RULE5
			fire = (r.lat_cnt + 8'h1 >= r.lat); // see RULE6
			n.lat_cnt = fire ? 8'h0 : r.lat_cnt + 8'h1;
		end
		if (fire) begin
			for (int i = 0; i < `DSW_NLIST; i++) begin
				// OR: any masked done; AND: all masked done
				grp = (|(r.done[i] & r.orm[i])) ||
					((r.andm[i] != 32'h0) && ((r.done[i] & r.andm[i]) == r.andm[i]));
				if (grp) begin
					n.irq[i] = 1'b1; // see RULE4
				end
			end
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.lat <= `DSW_RST_LAT;
		end else begin
			r <= n;
		end
	end

endmodule : dsw_walker

// File: dsw_defs.svh
/*
 * Constants of the descriptor schedule walker: sizes, timing,
 * register offsets, descriptor bit positions and codes.
 * Assumes inclusion by the package and the walker module only.
 */
`ifndef DSW_DEFS_SVH
`define DSW_DEFS_SVH
// Lists and slots
`define DSW_NLIST 3
`define DSW_LAST_LIST 2'h2
`define DSW_LAST_SLOT 5'h1f
// Timing: one microframe of core_clk cycles
`define DSW_CLK_NS 40
`define DSW_UFRAME_NS 125000
`define DSW_UFRAME_CYC ((`DSW_UFRAME_NS) / (`DSW_CLK_NS))
// Register groups, address bits 7:4
`define DSW_G_MISC 4'h0
`define DSW_G_DONE 4'h1
`define DSW_G_OR 4'h2
`define DSW_G_AND 4'h3
`define DSW_G_SKIP 4'h4
`define DSW_G_LAST 4'h5
// Index inside the misc group, and the unused list index, address bits 3:2
`define DSW_I_CTRL 2'h0
`define DSW_I_LAT 2'h1
`define DSW_I_IRQ 2'h2
`define DSW_I_STAT 2'h3
`define DSW_BAD_LIST 2'h3
// Reset values
`define DSW_RST_WORD 32'h0
`define DSW_RST_LAT 8'h1
// Descriptor words and bits
`define DSW_WORD3 3'h3
`define DSW_WORD4 3'h4
`define DSW_DW3_ACT 31
`define DSW_DW3_BAB 29
`define DSW_DW3_ERR 28
`define DSW_DW4_BR 5
`define DSW_RETRY_MAX 2'h3
// Transaction results
`define DSW_XS_OK 2'h0
`define DSW_XS_PID 2'h1
`define DSW_XS_BAB 2'h2
// Interrupt bits
`define DSW_IRQ_SOF 3
// Bus responses
`define DSW_RESP_OK 2'h0
`define DSW_RESP_SLV 2'h2
`endif

// File: dsw_pkg.sv
/*
 * Types of the descriptor schedule walker: states and state struct.
 * Assumes dsw_defs.svh is on the include path.
 */
`include "dsw_defs.svh"
package dsw_pkg;
	typedef logic [1:0] dsw_list_t; // 0 iso, 1 poll, 2 async
	typedef logic [4:0] dsw_slot_t;
	// Gray along idle-check-read-xact-writeback-read-next
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_CHK = 3'h1, ST_RD3 = 3'h3, ST_XACT = 3'h2,
		ST_WB = 3'h6, ST_RD4 = 3'h7, ST_NEXT = 3'h5
	} dsw_state_e;
	typedef struct packed {
		dsw_state_e st;
		dsw_list_t list;
		dsw_slot_t slot;
		logic [1:0] retry;
		logic [31:0] dw3;
		logic br;
		dsw_slot_t link;
		logic [11:0] tick_cnt;
		logic [7:0] lat_cnt;
		logic en;
		logic [7:0] lat;
		logic [3:0] irq;
		logic [2:0][31:0] done;
		logic [2:0][31:0] orm;
		logic [2:0][31:0] andm;
		logic [2:0][31:0] skip;
		logic [2:0][31:0] last;
		logic aw_ok;
		logic [7:0] awaddr;
		logic w_ok;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dsw_s;
endpackage : dsw_pkg

// File: dsw_walker_checker.sv
/* Port assertions for the walker: memory, engine and writeback.
 * Assumes binding onto dsw_walker, one clock domain. */
`timescale 1ns/1ps
module dsw_walker_checker
	import dsw_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [9:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic xact_req,
	input wire dsw_pkg::dsw_list_t xact_list,
	input wire dsw_pkg::dsw_slot_t xact_slot,
	input wire logic xact_ack,
	input wire logic [1:0] xact_status
);
	logic [2:0] pid_r; // Failed tries of the current descriptor
	// Counts PID answers of one request; cleared while no request stands
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) pid_r <= 3'h0;
		else if (!xact_req) pid_r <= 3'h0;
		else if (xact_ack) pid_r <= (xact_status == 2'h1) ? pid_r + 3'h1 : 3'h0;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("memory request dropped early");
	a_xact_hold: assert property (xact_req && !xact_ack |=> xact_req && $stable(xact_slot))
		else $error("transaction request dropped early");
	a_retry_more: assert property (xact_ack && xact_status == 2'h1 && pid_r < 3'h3 |=> xact_req)
		else $error("no retry after PID error");
	a_retry_stop: assert property (xact_ack && xact_status == 2'h1 && pid_r == 3'h3
		|=> !xact_req ##[0:3] (mem_we && mem_wdata[28] && !mem_wdata[31]))
		else $error("PID error writeback wrong");
	a_babble_wb: assert property (xact_ack && xact_status[1]
		|=> !xact_req ##[0:3] (mem_we && mem_wdata[29] && !mem_wdata[31]))
		else $error("babble writeback wrong");
	a_ok_wb: assert property (xact_ack && xact_status == 2'h0 |=> ##[0:3] (mem_we && !mem_wdata[31]))
		else $error("completed descriptor still active");
	a_wb_word: assert property (mem_we |-> mem_req && mem_addr == {xact_list, xact_slot, 3'h3})
		else $error("writeback to wrong word");
	a_xact_after: assert property ($rose(xact_req) |-> $past(mem_addr) == {xact_list, xact_slot, 3'h3})
		else $error("transaction without its descriptor read");
	a_list_legal: assert property (xact_req |-> xact_list != 2'h3)
		else $error("transaction on a fourth list");
endmodule : dsw_walker_checker
bind dsw_walker dsw_walker_checker chk_u (.*);

// File: dsw_far_model.sv
/* Far side: descriptor memory and transaction engine, random delays.
 * Assumes the bench fills mem, pid_left and fin before enabling. */
`timescale 1ns/1ps
module dsw_far_model (
	input wire logic core_clk,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [9:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ack,
	input wire logic xact_req,
	input wire logic [6:0] xact_id,
	output logic xact_ack,
	output logic [1:0] xact_status
);
	logic [31:0] mem [1024]; // Shared descriptor memory
	int pid_left [96]; // PID errors still to inject
	logic [1:0] fin [96]; // Answer once errors run out
	int log_q [$]; // Every engine answer, in order
	int md = 0;
	int xd = 0;
	initial begin
		mem_rdata = 32'h0;
		mem_ack = 1'b0;
		xact_ack = 1'b0;
		xact_status = 2'h0;
	end
	// Memory: data wanders when not acking, so stale reads show
	always @(posedge core_clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (md > 0) md <= md - 1;
			else begin
				mem_ack <= 1'b1;
				md <= $urandom % 3;
				if (mem_we) mem[mem_addr] <= mem_wdata;
				else mem_rdata <= mem[mem_addr];
			end
		end
	end
	// Engine: injected PID errors first, then the final answer
	always @(posedge core_clk) begin
		xact_ack <= 1'b0;
		xact_status <= ~xact_status;
		if (xact_req && !xact_ack) begin
			if (xd > 0) xd <= xd - 1;
			else begin
				xact_ack <= 1'b1;
				xd <= $urandom % 4;
				log_q.push_back(xact_id);
				xact_status <= (pid_left[xact_id] > 0) ? 2'h1 : fin[xact_id];
				if (pid_left[xact_id] > 0) pid_left[xact_id]--;
			end
		end
	end
endmodule : dsw_far_model

// File: descriptor_schedule_walker_tb_top.sv
/* Bench: random lists walked by the design and by a queue model.
 * Assumes the far model and the bound checker are compiled first. */
`timescale 1ns/1ps
module descriptor_schedule_walker_tb_top;
	import dsw_pkg::*;
	logic core_clk = 0;
	logic rst_n = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, mem_rdata, mem_wdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, mem_req, mem_we, mem_ack, xact_req, xact_ack;
	logic irq_iso, irq_poll, irq_async, irq_sof;
	logic [1:0] s_axi_bresp, s_axi_rresp, xact_status;
	logic [9:0] mem_addr;
	dsw_list_t xact_list;
	dsw_slot_t xact_slot;
	int n_fail = 0;
	int samples_checked = 0;
	dsw_walker dut_u (.*);
	dsw_far_model u_far (.xact_id({xact_list, xact_slot}), .*);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Write: both halves offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		aw = 1;
		w = 1;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (aw || w) begin
			@(posedge core_clk);
			if (aw && s_axi_awready) aw = 0;
			if (w && s_axi_wready) w = 0;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		while (!s_axi_bvalid) @(posedge core_clk);
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge core_clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask : rd
	task automatic finish_test;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	// Watchdog: well past reset, setup and four microframes
	initial begin
		repeat (40000) @(posedge core_clk);
		n_fail++;
		finish_test();
	end
	initial begin
		logic [31:0] v, w3, w4, sk [3], dn [3], x [96];
		logic [1:0] r;
		int e [$];
		int lst [3];
		int s, i, p;
		void'($urandom(43));
		repeat (16) @(posedge core_clk);
		rst_n <= 1;
		rd(8'h04, v, r);
		chk("latency reset", v, 32'h1);
		rd(8'h1c, v, r);
		chk("fourth list resp", r, 2'h2);
		p = $urandom % 256;
		wr(8'h04, p, r);
		chk("latency write resp", r, 2'h0);
		rd(8'h04, v, r);
		chk("latency rw", v, p);
		wr(8'h3c, 32'h1, r);
		chk("bad list write resp", r, 2'h2);
		wr(8'h04, 32'h1, r);
		$display("test registers done");
		// Random lists; software keeps forward link targets short of final and unskipped
		for (int k = 0; k < 3; k++) begin
			// Only the iso list groups by OR; the others by AND below
			wr(8'h20 + 8'(4 * k), (k == 0) ? 32'hffffffff : 32'h0, r);
			sk[k] = $urandom;
			lst[k] = $urandom % 32;
			for (s = 0; s < 32; s++) begin // Every slot a channel of its own
				i = k * 32 + s;
				w4 = $urandom % 64; // One endpoint per slot
				if (w4[4:0] > s && w4[4:0] >= lst[k]) w4[5] = 0;
				if (w4[5] && w4[4:0] > s) sk[k][w4[4:0]] = 0;
				x[i] = $urandom;
				u_far.mem[i * 8 + 3] = x[i];
				u_far.mem[i * 8 + 4] = w4;
				u_far.pid_left[i] = $urandom % 5;
				u_far.fin[i] = ($urandom % 2) ? 2'h2 : 2'h0;
			end
			wr(8'h40 + 8'(4 * k), sk[k], r);
			wr(8'h50 + 8'(4 * k), 32'h1 << lst[k], r);
		end
		// Reference walk: order of engine answers and writebacks
		for (int k = 0; k < 3; k++) begin
			dn[k] = 0;
			s = 0;
			while (1) begin
				i = k * 32 + s;
				w3 = x[i];
				w4 = u_far.mem[i * 8 + 4];
				p = u_far.pid_left[i];
				if (!sk[k][s] && w3[31]) begin
					repeat (p > 3 ? 4 : p + 1) e.push_back(i);
					dn[k][s] = 1;
					x[i] = (w3 & 32'h7fffffff)
						| (p > 3 ? 32'h10000000 : u_far.fin[i][1] ? 32'h20000000 : 32'h0);
				end
				if (s == lst[k] || s == 31) break;
				s = (!sk[k][s] && w4[5] && w4[4:0] > s) ? int'(w4[4:0]) : s + 1;
			end
		end
		// Poll list needs all 32 done; async list exactly its done set
		wr(8'h34, 32'hffffffff, r);
		wr(8'h38, dn[2], r);
		wr(8'h08, 32'hf, r);
		wr(8'h00, 32'h1, r);
		repeat (4 * 3125) @(posedge core_clk);
		chk("answer count", u_far.log_q.size(), e.size());
		foreach (e[j]) if (j < u_far.log_q.size()) chk("slot order", u_far.log_q[j], e[j]);
		for (i = 0; i < 96; i++) chk("word three", u_far.mem[i * 8 + 3], x[i]);
		for (int k = 0; k < 3; k++) begin
			rd(8'h10 + 8'(4 * k), v, r);
			chk("done map", v, dn[k]);
		end
		rd(8'h08, v, r);
		chk("irq reg", v, {28'h0, 1'b1, |dn[2], &dn[1], |dn[0]});
		chk("irq pins", {irq_sof, irq_async, irq_poll, irq_iso}, {1'b1, |dn[2], &dn[1], |dn[0]});
		chk("sof pin", irq_sof, 1'b1);
		$display("test walk done");
		finish_test();
	end
endmodule : descriptor_schedule_walker_tb_top
